//--- testbench/hv_wake_input_detector_tb.sv
`timescale 1ns/1ps
`include "wake_input_map.svh"

module hv_wake_input_detector_tb;
	import wake_input_pkg::*;
	// Bench signals
	logic        clk_i;
	logic        rst_i;
	logic        hsel;
	logic        hwrite;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata_o;
	logic        hreadyout_o;
	logic        hresp_o;
	logic        wpin;
	logic        gpin;
	chip_mode_t  mode;
	logic        win;
	logic        pull_up_en_o;
	logic        pull_down_en_o;
	logic        wake_up_o;
	logic        interrupt_out_n_o;
	int          errors;
	int          cmp_count;
	int          wake_cnt = 0;

	// Clock at 50 ns
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	hv_wake_input_detector dut (
		.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
		.hwdata_i(hwdata), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hv_wake_pin_i(wpin),
		.fail_or_general_pin_i(gpin), .chip_mode_i(mode),
		.cyclic_window_i(win), .pull_up_en_o(pull_up_en_o),
		.pull_down_en_o(pull_down_en_o), .wake_up_o(wake_up_o),
		.interrupt_out_n_o(interrupt_out_n_o)
	);

	wake_source_model src (.clk_i(clk_i), .wake_o(wpin), .gen_o(gpin));

	// Count wake pulses
	always @(posedge clk_i) begin
		if (wake_up_o === 1'b1)
			wake_cnt <= wake_cnt + 1;
	end

	task automatic print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("FAIL %0t: got %h want %h", $time, s, e);
		end
	endtask : check

	// Wait for hready under a bound
	task automatic rdy;
		int n;
		n = 0;
		@(posedge clk_i);
		while (hreadyout_o !== 1'b1) begin
			n++;
			if (n > 50) begin
				errors++;
				print_verdict;
			end
			@(posedge clk_i);
		end
	endtask : rdy

	// One AHB-Lite single transfer
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		hsize  <= 3'h2;
		haddr  <= a;
		rdy;
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
		q = hrdata_o;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q, e);
	endtask : rc

	// Let cycles pass, then sample settled outputs
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : wt

	task automatic irq(input logic e);
		check({31'h0, interrupt_out_n_o}, {31'h0, e});
	endtask : irq

	// Reset values and unmapped access
	task automatic s_reset;
		rc(`WAKE_PIN_CONTROL_OFS, `CTRL_RESET);
		rc(`WAKE_PULL_CONTROL_OFS, 32'h0);
		rc(`WAKE_IRQ_MASK_OFS, 32'h3);
		rc(`WAKE_EVENT_STATUS_OFS, 32'h0);
		wr(8'h18, 32'hFFFF_FFFF);
		rc(8'h18, 32'h0);
		check({31'h0, hresp_o}, 32'h0);
		irq(1'b1);
	endtask : s_reset

	// Rising edge in normal mode, then a glitch
	task automatic s_normal;
		mode <= MODE_NORMAL;
		src.drive(1'b1);
		wt(400);
		irq(1'b0);
		check(wake_cnt, 0);
		rc(`WAKE_EVENT_STATUS_OFS, 32'h1);
		rc(`WAKE_PIN_LEVEL_STATUS_OFS, 32'h1);
		wr(`WAKE_EVENT_STATUS_OFS, 32'h1);
		wt(2);
		irq(1'b1);
		src.glitch(100);
		wt(400);
		rc(`WAKE_EVENT_STATUS_OFS, 32'h0);
		rc(`WAKE_PIN_LEVEL_STATUS_OFS, 32'h1);
	endtask : s_normal

	// Falling edge in sleep wakes the chip
	task automatic s_sleep;
		mode <= MODE_SLEEP;
		src.drive(1'b0);
		wt(400);
		check(wake_cnt, 1);
		irq(1'b1);
		rc(`WAKE_EVENT_STATUS_OFS, 32'h1);
		mode <= MODE_NORMAL;
		wr(`WAKE_EVENT_STATUS_OFS, 32'h1);
	endtask : s_sleep

	// Masked event and every pull setting
	task automatic s_mask_pull;
		wr(`WAKE_IRQ_MASK_OFS, 32'h0);
		src.drive(1'b1);
		wt(400);
		rc(`WAKE_EVENT_STATUS_OFS, 32'h1);
		irq(1'b1);
		wr(`WAKE_EVENT_STATUS_OFS, 32'h1);
		wr(`WAKE_IRQ_MASK_OFS, 32'h3);
		for (int p = 0; p < 4; p++) begin
			wr(`WAKE_PULL_CONTROL_OFS, p);
			wt(2);
			check({pull_up_en_o, pull_down_en_o}, (p == 3) ? 32'h2 : p);
		end
	endtask : s_mask_pull

	// Wake disabled, then measurement on
	task automatic s_disable;
		wr(`WAKE_PIN_CONTROL_OFS, 32'h0);
		src.drive(1'b0);
		wt(400);
		rc(`WAKE_EVENT_STATUS_OFS, 32'h0);
		check({pull_up_en_o, pull_down_en_o}, 32'h1);
		wr(`WAKE_PIN_CONTROL_OFS, 32'h5);
		src.drive(1'b1);
		wt(400);
		check({pull_up_en_o, pull_down_en_o}, 0);
		rc(`WAKE_PIN_LEVEL_STATUS_OFS, 32'h0);
		rc(`WAKE_EVENT_STATUS_OFS, 32'h0);
		wr(`WAKE_PIN_CONTROL_OFS, 32'h1);
		wt(400);
		wr(`WAKE_EVENT_STATUS_OFS, 32'h1);
	endtask : s_disable

	// Sampling window pulse
	task automatic pulse_win;
		@(posedge clk_i);
		win <= 1'b1;
		repeat (5) @(posedge clk_i);
		win <= 1'b0;
		wt(10);
	endtask : pulse_win

	// Cyclic sense samples only in the window
	task automatic s_cyclic;
		wr(`WAKE_PIN_CONTROL_OFS, 32'h3);
		pulse_win;
		wr(`WAKE_EVENT_STATUS_OFS, 32'h1);
		src.drive(1'b0);
		wt(400);
		rc(`WAKE_EVENT_STATUS_OFS, 32'h0);
		rc(`WAKE_PIN_LEVEL_STATUS_OFS, 32'h1);
		pulse_win;
		rc(`WAKE_EVENT_STATUS_OFS, 32'h1);
		rc(`WAKE_PIN_LEVEL_STATUS_OFS, 32'h0);
		wr(`WAKE_EVENT_STATUS_OFS, 32'h1);
		wr(`WAKE_PIN_CONTROL_OFS, 32'h1);
	endtask : s_cyclic

	// Alternate pin reports in its own register
	task automatic s_alt;
		mode <= MODE_STOP;
		wr(`WAKE_PIN_CONTROL_OFS, 32'h9);
		src.drive_gen(1'b1);
		wt(400);
		rc(`ALT_WAKE_EVENT_STATUS_OFS, 32'h1);
		rc(`WAKE_EVENT_STATUS_OFS, 32'h0);
		irq(1'b0);
		wr(`ALT_WAKE_EVENT_STATUS_OFS, 32'h1);
		wt(2);
		irq(1'b1);
		mode <= MODE_FAIL_SAFE;
		src.drive_gen(1'b0);
		wt(400);
		check(wake_cnt, 2);
		irq(1'b1);
		rc(`ALT_WAKE_EVENT_STATUS_OFS, 32'h1);
	endtask : s_alt

	// Main sequence
	initial begin
		rst_i     = 1'b1;
		hsel      = 1'b0;
		hwrite    = 1'b0;
		htrans    = 2'h0;
		hsize     = 3'h0;
		haddr     = 8'h0;
		hwdata    = 32'h0;
		mode      = MODE_INIT;
		win       = 1'b0;
		errors    = 0;
		cmp_count = 0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		s_reset;
		s_normal;
		s_sleep;
		s_mask_pull;
		s_disable;
		s_cyclic;
		s_alt;
		print_verdict;
	end
endmodule : hv_wake_input_detector_tb

//--- testbench/wake_source_model.sv
`timescale 1ns/1ps

module wake_source_model (
	// Clock
	input  wire logic clk_i,
	// Pin levels
	output logic      wake_o,
	output logic      gen_o
);
	// Pins start low, so reset alone raises no crossing
	initial begin
		wake_o = 1'b0;
		gen_o  = 1'b0;
	end

	// Move the wake pin just after an edge
	task automatic drive(input logic lvl);
		@(posedge clk_i);
		wake_o <= lvl;
	endtask : drive

	// Short excursion that the filter must swallow
	task automatic glitch(input int n);
		drive(~wake_o);
		repeat (n) @(posedge clk_i);
		wake_o <= ~wake_o;
	endtask : glitch

	// Move the alternate wake pin
	task automatic drive_gen(input logic lvl);
		@(posedge clk_i);
		gen_o <= lvl;
	endtask : drive_gen
endmodule : wake_source_model

//--- verilog/hv_wake_input_detector.sv
`timescale 1ns/1ps
`include "wake_input_map.svh"

module hv_wake_input_detector (
	// Clock and reset
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	// AHB-Lite slave
	input  wire logic                        hsel_i,
	input  wire logic [7:0]                  haddr_i,
	input  wire logic [1:0]                  htrans_i,
	input  wire logic                        hwrite_i,
	input  wire logic [2:0]                  hsize_i,
	input  wire logic [31:0]                 hwdata_i,
	input  wire logic                        hready_i,
	output logic      [31:0]                 hrdata_o,
	output logic                             hreadyout_o,
	output logic                             hresp_o,
	// Wake pin comparator and alternate general pin
	input  wire logic                        hv_wake_pin_i,
	input  wire logic                        fail_or_general_pin_i,
	// Chip mode and cyclic sense timer window
	input  wire wake_input_pkg::chip_mode_t  chip_mode_i,
	input  wire logic                        cyclic_window_i,
	// Pull current source controls
	output logic                             pull_up_en_o,
	output logic                             pull_down_en_o,
	// Wake request and interrupt
	output logic                             wake_up_o,
	output logic                             interrupt_out_n_o
);
	import wake_input_pkg::*;

	// Registers
	logic [3:0]  wake_pin_control_q;
	pull_sel_t   wake_pull_control_q;
	logic        wake_pin_event_flag_q;
	logic        alt_wake_event_q;
	logic        wake_pin_level_status_q;
	logic [1:0]  irq_mask_q;
	logic        wake_up_q;
	logic [31:0] hrdata_q;
	logic        win_d1_q;
	logic        win_level_q;

	// Bus address phase capture
	logic        ph_valid_q;
	logic        ph_write_q;
	logic [7:0]  ph_addr_q;

	// Decoded control bits
	logic wake_en;
	logic cyclic_sel;
	logic measure_en;
	logic alt_en;
	assign wake_en    = wake_pin_control_q[`CTRL_WAKE_EN_BIT];
	assign cyclic_sel = wake_pin_control_q[`CTRL_CYCLIC_BIT];
	assign measure_en = wake_pin_control_q[`CTRL_MEASURE_BIT];
	assign alt_en     = wake_pin_control_q[`CTRL_ALT_EN_BIT];

	// Synchronised comparator levels
	logic pin_level;
	logic pin_change;
	logic alt_level;
	logic alt_change;

	pin_synchroniser u_pin_sync (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.async_i  (hv_wake_pin_i),
		.level_o  (pin_level),
		.change_o (pin_change)
	);

	pin_synchroniser u_alt_sync (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.async_i  (fail_or_general_pin_i),
		.level_o  (alt_level),
		.change_o (alt_change)
	);

	// Static path filters; the pin filter keeps tracking under measurement
	logic pin_evt;
	logic pin_flt_level;
	logic alt_evt;

	wake_filter u_pin_filter (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.level_i  (pin_level),
		.change_i (pin_change),
		.event_o  (pin_evt),
		.level_o  (pin_flt_level)
	);

	wake_filter u_alt_filter (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.level_i  (alt_level),
		.change_i (alt_change),
		.event_o  (alt_evt),
		.level_o  ()
	);

	// Cyclic sampling at the end of each timer window
	logic sample_now;
	logic cyc_evt;
	assign sample_now = cyclic_sel && win_d1_q && !cyclic_window_i;
	assign cyc_evt    = sample_now && (win_level_q != wake_pin_level_status_q);

	// Window edge detector and the level last seen inside the window
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			win_d1_q    <= 1'b0;
			win_level_q <= 1'b0;
		end else begin
			win_d1_q <= cyclic_window_i;
			if (cyclic_window_i) begin
				win_level_q <= pin_level;
			end
		end
	end

	// Qualified wake events from either edge
	logic wk_event;
	logic alt_event;
	assign wk_event  = wake_en && !measure_en
		&& (cyclic_sel ? cyc_evt : pin_evt);
	assign alt_event = alt_en && alt_evt;

	// Level status: live, sampled, or cleared under measurement
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wake_pin_level_status_q <= 1'b0;
		end else if (measure_en) begin
			wake_pin_level_status_q <= 1'b0;
		end else if (cyclic_sel) begin
			if (sample_now) begin
				wake_pin_level_status_q <= win_level_q;
			end
		end else if (chip_mode_i == MODE_NORMAL || chip_mode_i == MODE_STOP
			|| chip_mode_i == MODE_INIT) begin
			wake_pin_level_status_q <= pin_flt_level;
		end
	end

	// Pull sources; automatic follows detected level
	always_comb begin
		pull_up_en_o   = 1'b0;
		pull_down_en_o = 1'b0;
		if (!measure_en) begin
			unique case (wake_pull_control_q)
				PULL_NONE: ;
				PULL_DOWN: pull_down_en_o = 1'b1;
				PULL_UP:   pull_up_en_o = 1'b1;
				PULL_AUTO: begin
					pull_up_en_o   = pin_level;
					pull_down_en_o = ~pin_level;
				end
			endcase
		end
	end

	// Mode dependent routing
	logic low_power;
	assign low_power = (chip_mode_i == MODE_SLEEP) || (chip_mode_i == MODE_FAIL_SAFE);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wake_up_q <= 1'b0;
		end else begin
			wake_up_q <= low_power && (wk_event || alt_event);
		end
	end
	assign wake_up_o = wake_up_q;

	// Bus write and status clear decode
	logic wr_en;
	logic rd_en;
	assign wr_en = ph_valid_q && ph_write_q;
	assign rd_en = hsel_i && hready_i && htrans_i[1] && !hwrite_i;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ph_valid_q <= 1'b0;
			ph_write_q <= 1'b0;
			ph_addr_q  <= 8'h00;
		end else if (hready_i) begin
			ph_valid_q <= hsel_i && htrans_i[1];
			ph_write_q <= hwrite_i;
			ph_addr_q  <= haddr_i;
		end
	end

	// Control registers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wake_pin_control_q  <= 4'(`CTRL_RESET);
			wake_pull_control_q <= pull_sel_t'(`PULL_RESET);
			irq_mask_q          <= `MASK_RESET;
		end else if (wr_en) begin
			unique case (ph_addr_q)
				`WAKE_PIN_CONTROL_OFS:  wake_pin_control_q <= hwdata_i[3:0];
				`WAKE_PULL_CONTROL_OFS: wake_pull_control_q <= pull_sel_t'(hwdata_i[1:0]);
				`WAKE_IRQ_MASK_OFS:     irq_mask_q <= hwdata_i[1:0];
				default: ;
			endcase
		end
	end

	// Sticky event flags; set wins over write-one clear
	logic clr_main;
	logic clr_alt;
	assign clr_main = wr_en && ph_addr_q == `WAKE_EVENT_STATUS_OFS
		&& hwdata_i[`STAT_EVENT_BIT];
	assign clr_alt  = wr_en && ph_addr_q == `ALT_WAKE_EVENT_STATUS_OFS
		&& hwdata_i[`STAT_EVENT_BIT];

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wake_pin_event_flag_q <= 1'b0;
		end else if (wk_event) begin
			wake_pin_event_flag_q <= 1'b1;
		end else if (clr_main) begin
			wake_pin_event_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			alt_wake_event_q <= 1'b0;
		end else if (alt_event) begin
			alt_wake_event_q <= 1'b1;
		end else if (clr_alt) begin
			alt_wake_event_q <= 1'b0;
		end
	end

	// Read data registered at the address phase
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hrdata_q <= 32'h0000_0000;
		end else if (rd_en) begin
			unique case (haddr_i)
				`WAKE_PIN_CONTROL_OFS:      hrdata_q <= {28'h0, wake_pin_control_q};
				`WAKE_PULL_CONTROL_OFS:     hrdata_q <= {30'h0, wake_pull_control_q};
				`WAKE_EVENT_STATUS_OFS:     hrdata_q <= {31'h0, wake_pin_event_flag_q};
				`ALT_WAKE_EVENT_STATUS_OFS: hrdata_q <= {31'h0, alt_wake_event_q};
				`WAKE_PIN_LEVEL_STATUS_OFS: hrdata_q <= {31'h0, wake_pin_level_status_q};
				`WAKE_IRQ_MASK_OFS:         hrdata_q <= {30'h0, irq_mask_q};
				default:                    hrdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign hrdata_o    = hrdata_q;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;

	// Interrupt only in active modes, from masked sticky flags
	logic irq_active;
	assign irq_active = !low_power
		&& |({alt_wake_event_q, wake_pin_event_flag_q} & irq_mask_q);
	assign interrupt_out_n_o = ~irq_active;

	// Low power event wakes the device next cycle
	wake_sleep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wk_event && low_power) |=> wake_up_o)
		else $error("no wake-up from low power event");

	// Alternate pin event in low power wakes too
	wake_alt_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(alt_event && low_power) |=> wake_up_o)
		else $error("no wake-up from alternate event");

	// Active mode never wakes
	wake_active_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(!$past(low_power) && !low_power) |-> !wake_up_o)
		else $error("wake-up raised in active mode");

	// Masked event in active mode pulls interrupt low
	irq_event_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wk_event && irq_mask_q[0] && !low_power)
		|=> (!interrupt_out_n_o || low_power))
		else $error("interrupt missing after event");

	// Low power modes keep the interrupt released
	irq_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
		low_power |-> interrupt_out_n_o)
		else $error("interrupt driven in low power mode");

	// Event sets the flag even with a clear
	event_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wk_event |=> wake_pin_event_flag_q)
		else $error("wake event flag not set");

	// Write one clears the flag when no event competes
	flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(clr_main && !wk_event) |=> !wake_pin_event_flag_q)
		else $error("wake event flag not cleared");

	// Alternate events land in their own flag
	alt_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		alt_event |=> alt_wake_event_q)
		else $error("alternate wake flag not set");

	// Alternate flag clears on write one without event
	alt_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(clr_alt && !alt_event) |=> !alt_wake_event_q)
		else $error("alternate wake flag not cleared");

	// Disabled wake gives no event
	wake_disable_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!wake_en |-> !wk_event)
		else $error("event while wake disabled");

	// Measurement clears level and disables pulls
	measure_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		measure_en ##1 measure_en |-> !wake_pin_level_status_q
		&& !pull_up_en_o && !pull_down_en_o && !wk_event)
		else $error("measurement did not gate wake path");

	// Static level status follows the filtered level in active modes
	level_live_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(!measure_en && !cyclic_sel && (chip_mode_i == MODE_NORMAL
		|| chip_mode_i == MODE_STOP || chip_mode_i == MODE_INIT))
		|=> wake_pin_level_status_q == $past(pin_flt_level))
		else $error("level status not following pin");

	// Cyclic level changes only at window end
	cyclic_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(cyclic_sel && $past(cyclic_sel) && !measure_en && !$past(measure_en)
		&& !$past(sample_now)) |-> $stable(wake_pin_level_status_q))
		else $error("cyclic level changed outside sample");

	// Sample stores the level seen inside the window
	cyclic_sample_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(sample_now && !measure_en) |=> wake_pin_level_status_q == $past(win_level_q))
		else $error("cyclic sample not stored");

	// Cyclic window closed means no event
	cyclic_window_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(cyclic_sel && !win_d1_q) |-> !wk_event)
		else $error("event outside cyclic window");

	// Automatic pull follows level
	pull_auto_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wake_pull_control_q == PULL_AUTO && !measure_en)
		|-> pull_up_en_o == pin_level && pull_down_en_o != pin_level)
		else $error("automatic pull wrong");

endmodule : hv_wake_input_detector

//--- verilog/pin_synchroniser.sv
`timescale 1ns/1ps
`include "wake_input_map.svh"

module pin_synchroniser (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Raw asynchronous level
	input  wire logic async_i,
	// Stable level and one-cycle change pulse
	output logic      level_o,
	output logic      change_o
);

	logic [2:0] sync_q;
	logic       level_q;

	// Three stages; the first is read only by the second
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync_q <= 3'h0;
		end else begin
			sync_q <= {sync_q[1:0], async_i};
		end
	end

	// Accept a change once stages two and three agree
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			level_q <= 1'b0;
		end else if (sync_q[1] == sync_q[2]) begin
			level_q <= sync_q[2];
		end
	end

	assign level_o  = level_q;
	assign change_o = (sync_q[1] == sync_q[2]) && (sync_q[2] != level_q);

endmodule : pin_synchroniser

//--- verilog/wake_filter.sv
`timescale 1ns/1ps
`include "wake_input_map.svh"

module wake_filter (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Synchronised level and its change pulse
	input  wire logic level_i,
	input  wire logic change_i,
	// Filtered event pulse and accepted level
	output logic      event_o,
	output logic      level_o
);
	import wake_input_pkg::*;

	localparam int unsigned CNT_W = 10;
	localparam logic [CNT_W-1:0] LAST = CNT_W'(`FILTER_CYCLES - 1);

	filter_state_t    state_q;
	logic [CNT_W-1:0] cnt_q;
	logic             level_q;
	logic             event_q;

	// Filter: restart on every crossing, accept after the full time
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= FLT_IDLE;
			cnt_q   <= '0;
			level_q <= 1'b0;
			event_q <= 1'b0;
		end else begin
			event_q <= 1'b0;
			if (change_i) begin
				state_q <= FLT_RUN;
				cnt_q   <= '0;
			end else begin
				unique case (state_q)
					FLT_IDLE: begin
						cnt_q <= '0;
					end
					FLT_RUN: begin
						if (level_i == level_q) begin
							state_q <= FLT_IDLE;
						end else if (cnt_q == LAST) begin
							state_q <= FLT_IDLE;
							level_q <= level_i;
							event_q <= 1'b1;
						end else begin
							cnt_q <= cnt_q + 1'b1;
						end
					end
				endcase
			end
		end
	end

	assign event_o = event_q;
	assign level_o = level_q;

	// An accepted event sees the same level as two cycles before
	filter_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(event_q) |-> $past(level_i, 2) == level_i)
		else $error("filter accepted an unstable level");

	// A change always restarts the count
	filter_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
		change_i |=> (cnt_q == '0) && !event_q)
		else $error("filter did not restart on crossing");

endmodule : wake_filter

//--- verilog/wake_input_map.svh
`ifndef WAKE_INPUT_MAP_SVH
`define WAKE_INPUT_MAP_SVH

// Register byte offsets
`define WAKE_PIN_CONTROL_OFS      8'h00
`define WAKE_PULL_CONTROL_OFS     8'h04
`define WAKE_EVENT_STATUS_OFS     8'h08
`define ALT_WAKE_EVENT_STATUS_OFS 8'h0C
`define WAKE_PIN_LEVEL_STATUS_OFS 8'h10
`define WAKE_IRQ_MASK_OFS         8'h14

// Control and status field positions
`define CTRL_WAKE_EN_BIT   0
`define CTRL_CYCLIC_BIT    1
`define CTRL_MEASURE_BIT   2
`define CTRL_ALT_EN_BIT    3
`define STAT_EVENT_BIT     0

// Reset values
`define CTRL_RESET  32'h0000_0001
`define PULL_RESET  2'h0
`define MASK_RESET  2'h3

// Filter timing
`define CLK_PERIOD_NS    50
`define FILTER_TIME_NS   16000
`define FILTER_CYCLES    ((`FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- verilog/wake_input_pkg.sv
package wake_input_pkg;

	// Chip operating mode as seen by the wake logic
	typedef enum logic [2:0] {
		MODE_INIT,
		MODE_NORMAL,
		MODE_STOP,
		MODE_SLEEP,
		MODE_FAIL_SAFE
	} chip_mode_t;

	// Pull current source selection
	typedef enum logic [1:0] {
		PULL_NONE,
		PULL_DOWN,
		PULL_UP,
		PULL_AUTO
	} pull_sel_t;

	// Filter progress
	typedef enum logic [1:0] {
		FLT_IDLE,
		FLT_RUN
	} filter_state_t;

endpackage : wake_input_pkg
